/* include/svw_pkg.sv */
// constants for the supervisory reset and watchdog block
package svw_pkg;
   // system clock
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // timebase tick period
   localparam int unsigned TICK_US = 100;
   localparam int unsigned TICK_CYCLES = TICK_US * 1000 * 1000 / CLK_PERIOD_PS;
   // reset hold time after every cause clears
   localparam int unsigned HOLD_MS = 215;
   localparam int unsigned HOLD_MIN_MS = 140;
   localparam int unsigned HOLD_TICKS = HOLD_MS * 1000 / TICK_US;
   // watchdog period
   localparam int unsigned WD_PERIOD_MS = 1500;
   localparam int unsigned WD_TICKS = WD_PERIOD_MS * 1000 / TICK_US;
   // internal kick driver: low share of the watchdog period, full cycle
   localparam int unsigned DRV_LOW_PERMILLE = 875;
   localparam int unsigned DRV_LOW_TICKS = WD_TICKS * DRV_LOW_PERMILLE / 1000;
   localparam int unsigned DRV_CYCLE_MS = 1400;
   localparam int unsigned DRV_CYCLE_TICKS = DRV_CYCLE_MS * 1000 / TICK_US;
   // shortest kick pulse that must be seen
   localparam int unsigned KICK_MIN_NS = 50;
   localparam int unsigned KICK_MIN_CYCLES = KICK_MIN_NS * 1000 / CLK_PERIOD_PS;
   // manual reset glitch rejection, longest time so rounded down
   localparam int unsigned MR_REJECT_NS = 90;
   localparam int unsigned MR_FILT_CYCLES = MR_REJECT_NS * 1000 / CLK_PERIOD_PS;
   localparam int unsigned MR_MIN_PULSE_US = 1;
   // reset values
   localparam logic RST_ACTIVE_INIT = 1'b1;
   localparam logic KICK_DRV_INIT = 1'b0;
endpackage : svw_pkg

/* include/svw_tick_if.sv */
// timebase tick carrier between tick generator and supervisor core
`timescale 1ns/1ps
`default_nettype none
interface svw_tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface : svw_tick_if
`default_nettype wire

/* verilog/svw_tick_gen.sv */
// timebase tick generator: one-cycle pulse every TICK_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module svw_tick_gen
   import svw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // tick out
   svw_tick_if.src tick_if
);
   localparam int W = $clog2(TICK_CYCLES_P);

   generate
      if (TICK_CYCLES_P < 2) begin : g_bad
         $error("svw_tick_gen: TICK_CYCLES_P must be at least 2");
      end
   endgenerate

   logic [W-1:0] cnt_reg;
   logic tick_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (cnt_reg == W'(TICK_CYCLES_P - 1)) begin
         cnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   assign tick_if.tick = tick_reg;
endmodule : svw_tick_gen
`default_nettype wire

/* verilog/svw_top.sv */
// supervisory reset generator with supply monitor, manual reset and watchdog
`timescale 1ns/1ps
`default_nettype none
module svw_top
   import svw_pkg::*;
#(
   parameter bit ACTIVE_LOW = 1'b1,
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
   parameter int unsigned HOLD_TICKS_P = HOLD_TICKS,
   parameter int unsigned WD_TICKS_P = WD_TICKS,
   parameter int unsigned DRV_LOW_TICKS_P = DRV_LOW_TICKS,
   parameter int unsigned DRV_CYCLE_TICKS_P = DRV_CYCLE_TICKS,
   parameter int unsigned MR_FILT_CYCLES_P = MR_FILT_CYCLES
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   // supply comparator
   input wire logic SUPPLY_LOW,
   // manual reset pin, pulled up outside
   input wire logic MANUAL_RESET_IN_LOW,
   // watchdog kick pin
   input wire logic WATCHDOG_KICK_IN,
   output logic WATCHDOG_KICK_OUT,
   output logic WATCHDOG_KICK_OE_N,
   // reset to the processor
   output logic RESET_LOW_OUTPUT
);
   localparam int HW = $clog2(HOLD_TICKS_P + 1);
   localparam int WW = $clog2(WD_TICKS_P + 1);
   localparam int DW = $clog2(DRV_CYCLE_TICKS_P + 1);
   localparam int FW = $clog2(MR_FILT_CYCLES_P + 1);

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   generate
      if (HOLD_TICKS_P < 1 || WD_TICKS_P < 2 || MR_FILT_CYCLES_P < 1) begin : g_bad_cnt
         $error("svw_top: counts too small");
      end
      if (DRV_LOW_TICKS_P >= DRV_CYCLE_TICKS_P || DRV_CYCLE_TICKS_P >= WD_TICKS_P) begin : g_bad_drv
         $error("svw_top: kick driver must pulse within the watchdog period");
      end
      if (HOLD_MS < HOLD_MIN_MS) begin : g_bad_hold
         $error("svw_top: hold time below minimum");
      end
   endgenerate

   // ----------------------------------------------------------------
   // timebase
   // ----------------------------------------------------------------
   svw_tick_if tick_if ();

   svw_tick_gen #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_tick (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .tick_if(tick_if)
   );

   logic tick;
   assign tick = tick_if.tick;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // bit 0 supply low, bit 1 manual low, bit 2 kick
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic kick_prev_reg;

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         meta_reg <= 3'h3;
         sync_reg <= 3'h3;
         kick_prev_reg <= 1'b0;
      end else begin
         meta_reg <= {WATCHDOG_KICK_IN, ~MANUAL_RESET_IN_LOW, SUPPLY_LOW};
         sync_reg <= meta_reg;
         kick_prev_reg <= sync_reg[2];
      end
   end

   logic supply_low_s;
   logic mr_low_s;
   logic kick_edge;
   assign supply_low_s = sync_reg[0];
   assign mr_low_s = sync_reg[1];
   // any level change counts, so a single 50 ns pulse gives two edges
   assign kick_edge = sync_reg[2] ^ kick_prev_reg;

   // ----------------------------------------------------------------
   // manual reset glitch filter
   // ----------------------------------------------------------------
   // short spikes are rejected; a held low (or a bouncing switch) becomes
   // active and restarts the hold on every low, so bounce merges
   logic [FW-1:0] mr_cnt_reg;
   logic mr_active_reg;

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         mr_cnt_reg <= '0;
         mr_active_reg <= 1'b0;
      end else if (!mr_low_s) begin
         mr_cnt_reg <= '0;
         mr_active_reg <= 1'b0;
      end else if (mr_cnt_reg == FW'(MR_FILT_CYCLES_P)) begin
         mr_active_reg <= 1'b1;
      end else begin
         mr_cnt_reg <= mr_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // reset hold
   // ----------------------------------------------------------------
   logic wd_expire_reg;
   logic cause;
   logic rst_active_reg;
   logic [HW-1:0] hold_cnt_reg;

   assign cause = supply_low_s | mr_active_reg | wd_expire_reg;

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         rst_active_reg <= RST_ACTIVE_INIT;
         hold_cnt_reg <= '0;
      end else if (cause) begin
         rst_active_reg <= 1'b1;
         hold_cnt_reg <= '0;
      end else if (rst_active_reg && tick) begin
         if (hold_cnt_reg == HW'(HOLD_TICKS_P - 1)) begin
            rst_active_reg <= 1'b0;
            hold_cnt_reg <= '0;
         end else begin
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // watchdog counter
   // ----------------------------------------------------------------
   logic [WW-1:0] wd_cnt_reg;

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         wd_cnt_reg <= '0;
         wd_expire_reg <= 1'b0;
      end else if (rst_active_reg || kick_edge) begin
         wd_cnt_reg <= '0;
         wd_expire_reg <= 1'b0;
      end else if (tick && wd_cnt_reg == WW'(WD_TICKS_P - 1)) begin
         wd_cnt_reg <= '0;
         wd_expire_reg <= 1'b1;
      end else begin
         if (tick) begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
         end
         wd_expire_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // internal kick driver
   // ----------------------------------------------------------------
   // weak driver behind a series resistor: an external source overrides it,
   // and left alone its low-high-low pulse services the watchdog
   logic [DW-1:0] drv_cnt_reg;
   logic kick_drv_reg;

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         drv_cnt_reg <= '0;
      end else if (tick) begin
         if (drv_cnt_reg == DW'(DRV_CYCLE_TICKS_P - 1)) begin
            drv_cnt_reg <= '0;
         end else begin
            drv_cnt_reg <= drv_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         kick_drv_reg <= KICK_DRV_INIT;
      end else begin
         kick_drv_reg <= (drv_cnt_reg >= DW'(DRV_LOW_TICKS_P));
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic rst_out_reg;
   logic kick_oe_n_reg;

   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         rst_out_reg <= ~ACTIVE_LOW;
         kick_oe_n_reg <= 1'b0;
      end else begin
         rst_out_reg <= rst_active_reg ^ ACTIVE_LOW;
         kick_oe_n_reg <= 1'b0;
      end
   end

   assign RESET_LOW_OUTPUT = rst_out_reg;
   assign WATCHDOG_KICK_OUT = kick_drv_reg;
   assign WATCHDOG_KICK_OE_N = kick_oe_n_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   property p_supply_asserts;
      supply_low_s |=> rst_active_reg;
   endproperty
   a_supply_asserts: assert property (p_supply_asserts) else $error("supply low without reset");

   property p_hold_full;
      $fell(rst_active_reg) |-> $past(hold_cnt_reg) == HW'(HOLD_TICKS_P - 1) && $past(tick)
         && !$past(cause);
   endproperty
   a_hold_full: assert property (p_hold_full) else $error("reset released before hold time");

   property p_expire_asserts;
      wd_expire_reg |=> rst_active_reg ##1 rst_active_reg;
   endproperty
   a_expire_asserts: assert property (p_expire_asserts) else $error("expiry without reset");

   property p_wd_held;
      rst_active_reg |=> wd_cnt_reg == '0 && !wd_expire_reg;
   endproperty
   a_wd_held: assert property (p_wd_held) else $error("watchdog moved during reset");

   property p_wd_start;
      $fell(rst_active_reg) |-> wd_cnt_reg == '0;
   endproperty
   a_wd_start: assert property (p_wd_start) else $error("watchdog not zero at release");

   property p_kick_clears;
      kick_edge |=> wd_cnt_reg == '0 && !wd_expire_reg;
   endproperty
   a_kick_clears: assert property (p_kick_clears) else $error("kick did not clear watchdog");

   property p_drv_low;
      drv_cnt_reg < DW'(DRV_LOW_TICKS_P) |=> !WATCHDOG_KICK_OUT;
   endproperty
   a_drv_low: assert property (p_drv_low) else $error("kick driver high too early");

   property p_manual_asserts;
      $rose(mr_active_reg) |-> $past(mr_low_s, 1) ##1 rst_active_reg;
   endproperty
   a_manual_asserts: assert property (p_manual_asserts) else $error("manual reset ignored");

   property p_wd_tick_only;
      !tick && !rst_active_reg && !kick_edge |=> $stable(wd_cnt_reg);
   endproperty
   a_wd_tick_only: assert property (p_wd_tick_only) else $error("watchdog moved without tick");

   property p_polarity;
      ##1 RESET_LOW_OUTPUT == ($past(rst_active_reg) ^ ACTIVE_LOW);
   endproperty
   a_polarity: assert property (p_polarity) else $error("reset output polarity wrong");

   c_supply: cover property (supply_low_s ##1 rst_active_reg);
   c_manual: cover property ($rose(mr_active_reg));
   c_expire: cover property (wd_expire_reg);
   c_release: cover property ($fell(rst_active_reg));
endmodule : svw_top
`default_nettype wire

/* tb/svw_cpu_model.sv */
// processor model: services the watchdog kick pin and counts the resets it receives
`timescale 1ns/1ps
`default_nettype none
module svw_cpu_model (
   // clock and observed reset
   input wire logic clk,
   input wire logic reset_active,
   // kick pin drive
   output logic kick_val,
   output logic kick_en
);
   int resets_seen = 0;
   initial begin
      kick_val = 1'b0;
      kick_en = 1'b0;
   end
   always @(posedge reset_active) resets_seen++;
   // a released pin leaves the device's own weak driver in charge
   task automatic float_pin();
      @(negedge clk);
      kick_en = 1'b0;
   endtask : float_pin
   task automatic hold_pin(input logic lvl);
      @(negedge clk);
      kick_val = lvl;
      kick_en = 1'b1;
   endtask : hold_pin
   // pulses spaced under the watchdog period; each pulse gives two edges
   task automatic service(input int n, input int gap, input int width);
      repeat (n) begin
         repeat (gap) @(negedge clk);
         kick_val = ~kick_val;
         repeat (width) @(negedge clk);
         kick_val = ~kick_val;
      end
   endtask : service
endmodule : svw_cpu_model
`default_nettype wire

/* tb/svw_tb_top.sv */
// testbench for the supervisory reset block with a processor model
`timescale 1ns/1ps
`default_nettype none
module svw_tb_top;
   // ----------------------------------------
   // shortened counts, expectations derive from them
   // ----------------------------------------
   localparam int TK = 4;
   localparam int HOLD = 5;
   localparam int WD = 40;
   localparam int DLOW = 30;
   localparam int DCYC = 35;
   // hold release may land one tick early or late plus sync latency
   localparam int HLO = (HOLD - 1) * TK;
   localparam int HHI = (HOLD + 1) * TK + 6;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic supply_low = 1'b0;
   logic mr_val = 1'b1;
   logic mr_en = 1'b0;
   logic cpu_kick, cpu_en, kick_out, kick_oe_n, rst_low, rst_hi;
   int mismatches = 0;
   int checks_done = 0;
   wire logic mr_pin = mr_en ? mr_val : 1'b1;
   wire logic kick_pin = cpu_en ? cpu_kick : ((kick_oe_n === 1'b0) ? kick_out : 1'b0);
   wire logic rst_act = (rst_low === 1'b0);
   initial forever #2.5 clk = ~clk;
   svw_top #(.ACTIVE_LOW(1'b1), .TICK_CYCLES_P(TK), .HOLD_TICKS_P(HOLD), .WD_TICKS_P(WD),
      .DRV_LOW_TICKS_P(DLOW), .DRV_CYCLE_TICKS_P(DCYC), .MR_FILT_CYCLES_P(3)) dut_u (
      .CLK_SYS(clk), .SYS_RST(sys_rst), .SUPPLY_LOW(supply_low),
      .MANUAL_RESET_IN_LOW(mr_pin), .WATCHDOG_KICK_IN(kick_pin),
      .WATCHDOG_KICK_OUT(kick_out), .WATCHDOG_KICK_OE_N(kick_oe_n),
      .RESET_LOW_OUTPUT(rst_low));
   // active-high variant shares every input
   svw_top #(.ACTIVE_LOW(1'b0), .TICK_CYCLES_P(TK), .HOLD_TICKS_P(HOLD), .WD_TICKS_P(WD),
      .DRV_LOW_TICKS_P(DLOW), .DRV_CYCLE_TICKS_P(DCYC), .MR_FILT_CYCLES_P(3)) dut_hi_u (
      .CLK_SYS(clk), .SYS_RST(sys_rst), .SUPPLY_LOW(supply_low),
      .MANUAL_RESET_IN_LOW(mr_pin), .WATCHDOG_KICK_IN(kick_pin),
      .WATCHDOG_KICK_OUT(), .WATCHDOG_KICK_OE_N(), .RESET_LOW_OUTPUT(rst_hi));
   svw_cpu_model cpu_u (.clk(clk), .reset_active(rst_act), .kick_val(cpu_kick),
      .kick_en(cpu_en));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check
   task automatic wait_rst(input logic want, input int lim, output int n);
      n = 0;
      while (rst_act !== want && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_rst
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power_on();
      int n;
      check(rst_act, 1'b1, "under system reset");
      sys_rst = 1'b0;
      wait_rst(1'b0, 80, n);
      check(n >= HLO && n <= HHI, 1'b1, "power-on hold");
      repeat (20) @(negedge clk);
      check(rst_act, 1'b0, "open manual pin");
      $display("test power_on done");
   endtask : t_power_on
   task automatic t_supply();
      int n;
      supply_low = 1'b1;
      wait_rst(1'b1, 10, n);
      check(n >= 3 && n <= 5, 1'b1, "supply to reset");
      repeat (30) @(negedge clk);
      check(rst_act, 1'b1, "held while supply low");
      check(rst_hi, 1'b1, "variant polarity");
      supply_low = 1'b0;
      wait_rst(1'b0, 80, n);
      check(n >= HLO && n <= HHI, 1'b1, "supply hold");
      $display("test supply done");
   endtask : t_supply
   task automatic t_manual();
      int n;
      int r0;
      r0 = cpu_u.resets_seen;
      mr_en = 1'b1;
      mr_val = 1'b0;
      repeat (2) @(negedge clk);
      mr_val = 1'b1;
      repeat (20) @(negedge clk);
      check(cpu_u.resets_seen, r0, "glitch took effect");
      // contact bounce: short highs between lows must not split the reset
      for (int i = 0; i < 4; i++) begin
         mr_val = i[0];
         repeat (i[0] ? 3 : 8) @(negedge clk);
      end
      mr_val = 1'b0;
      // 200 cycles is the 1 us that the pin must stay low
      repeat (200) @(negedge clk);
      check(rst_act, 1'b1, "held while manual low");
      mr_val = 1'b1;
      wait_rst(1'b0, 80, n);
      check(n >= HLO && n <= HHI, 1'b1, "manual hold");
      check(cpu_u.resets_seen, r0 + 1, "bounce reset count");
      mr_en = 1'b0;
      $display("test manual done");
   endtask : t_manual
   task automatic t_watchdog();
      int n;
      int r0;
      cpu_u.hold_pin(1'b0);
      supply_low = 1'b1;
      repeat (8) @(negedge clk);
      supply_low = 1'b0;
      wait_rst(1'b0, 80, n);
      r0 = cpu_u.resets_seen;
      wait_rst(1'b1, WD * TK + 40, n);
      check(n >= (WD - 1) * TK && n <= (WD + 1) * TK + 6, 1'b1, "expiry time");
      wait_rst(1'b0, 80, n);
      check(n >= HLO && n <= HHI, 1'b1, "expiry hold");
      check(cpu_u.resets_seen, r0 + 1, "expiry count");
      $display("test watchdog done");
   endtask : t_watchdog
   task automatic t_service();
      int r0;
      r0 = cpu_u.resets_seen;
      // 10 cycles is the 50 ns shortest pulse
      cpu_u.service(4, (WD - 10) * TK, 10);
      check(cpu_u.resets_seen, r0, "serviced watchdog fired");
      $display("test service done");
   endtask : t_service
   task automatic t_float();
      int r0;
      int hi_cnt;
      r0 = cpu_u.resets_seen;
      cpu_u.float_pin();
      repeat (3 * WD * TK) @(negedge clk);
      check(cpu_u.resets_seen, r0, "undriven pin fired");
      hi_cnt = 0;
      repeat (DCYC * TK) begin
         @(negedge clk);
         hi_cnt += (kick_out === 1'b1);
      end
      check(hi_cnt, (DCYC - DLOW) * TK, "driver high share");
      check(kick_oe_n, 1'b0, "kick driver enabled");
      $display("test float done");
   endtask : t_float
   // a system reset in mid-run must restart the hold like power-on
   task automatic t_sys_reset();
      int n;
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      check(rst_act, 1'b1, "under mid-run reset");
      check(kick_oe_n, 1'b0, "kick driver enabled in reset");
      sys_rst = 1'b0;
      wait_rst(1'b0, 80, n);
      check(n >= HLO && n <= HHI, 1'b1, "mid-run reset hold");
      check(rst_hi, 1'b0, "active-high idle after reset");
      $display("test sys_reset done");
   endtask : t_sys_reset
   initial begin
      repeat (12) @(negedge clk);
      t_power_on();
      t_supply();
      t_manual();
      t_watchdog();
      t_service();
      t_float();
      t_sys_reset();
      test_done();
   end
   // about 1800 cycles expected; nearly three times that cuts a hang
   initial begin
      #25000;
      mismatches++;
      $display("unexpected at %0t: run did not finish", $time);
      test_done();
   end
endmodule : svw_tb_top
`default_nettype wire
